// ===== bench/rsq_board_model.sv
// Board model: supply, detector, oscillator, reset pin
`timescale 1ns/100ps
module rsq_board_model (
  // Clock and power-on reset
  input  wire mclk,
  input  wire sys_rst,
  // Bench requests
  input  wire pin_low,
  input  wire brown,
  // Lines into the sequencer
  output reg  ext_rst_n_pin,
  output reg  supply_ok,
  output reg  supply_drop_detector,
  output reg  osc_ready
);
  reg [3:0] ramp_ff; // Supply age, restarts on a drop
  // pin high at power-up
  // Oscillator dies with the supply, so it restarts too
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ramp_ff              <= 4'h0;
      ext_rst_n_pin        <= 1'b1;
      supply_ok            <= 1'b0;
      supply_drop_detector <= 1'b0;
      osc_ready            <= 1'b0;
    end else begin
      if (brown)
        ramp_ff <= 4'h0;
      else if (ramp_ff != 4'hF)
        ramp_ff <= ramp_ff + 4'h1;
      ext_rst_n_pin        <= ~pin_low;
      supply_drop_detector <= brown;
      supply_ok            <= ~brown && (ramp_ff >= 4'h8);
      osc_ready            <= ~brown && (ramp_ff >= 4'hC);
    end
  end
endmodule // rsq_board_model

// ===== bench/rsq_reset_sequencer_bench.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
`include "rsq_defs.vh"
module rsq_reset_sequencer_bench;
  // ****************************************
  // Signals
  // ****************************************
  reg         mclk, sys_rst, wdt_overflow, pin_low, brown;
  reg  [11:0] s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready;
  wire        ext_rst_n_pin, supply_ok, supply_drop_detector;
  wire        osc_ready, s_axi_awready, s_axi_wready;
  wire        cpu_rst_ff, pc_clear_ff, reg_init_ff, mode_normal_ff;
  wire        fetch_start_ff, irq_ff, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid;
  wire [10:0] boot_addr_ff;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     n_errors, checks;
  // Short counts keep the run brief
  rsq_reset_sequencer #(.SUPPLY_CYC(4), .WARM_CYC(6)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .ext_rst_n_pin(ext_rst_n_pin),
    .supply_ok(supply_ok), .supply_drop_detector(supply_drop_detector),
    .osc_ready(osc_ready), .wdt_overflow(wdt_overflow),
    .cpu_rst_ff(cpu_rst_ff), .pc_clear_ff(pc_clear_ff),
    .reg_init_ff(reg_init_ff), .mode_normal_ff(mode_normal_ff),
    .fetch_start_ff(fetch_start_ff), .boot_addr_ff(boot_addr_ff),
    .irq_ff(irq_ff), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  // Far side of the pins
  rsq_board_model u_brd (
    .mclk(mclk), .sys_rst(sys_rst), .pin_low(pin_low), .brown(brown),
    .ext_rst_n_pin(ext_rst_n_pin), .supply_ok(supply_ok),
    .supply_drop_detector(supply_drop_detector), .osc_ready(osc_ready));
  // ****************************************
  // Tasks
  // ****************************************
  // Compare and count
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for the core reset level
  task wait_cpu(input v);
    integer n;
    begin
      n = 0;
      while (cpu_rst_ff !== v && n < 300) begin
        @(posedge mclk);
        n = n + 1;
      end
      chk({31'h0, cpu_rst_ff}, {31'h0, v});
    end
  endtask
  // Bus write; design values are read before the edge lands
  task wr(input [11:0] idx, input [31:0] d, input [1:0] er);
    integer n;
    reg     aw, w;
    begin
      @(posedge mclk);
      s_axi_awaddr  <= {idx[9:0], 2'b00};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      while ((aw | w) && n < 50) begin
        @(posedge mclk);
        n = n + 1;
        if (aw && s_axi_awready === 1'b1) begin
          aw = 1'b0;
          s_axi_awvalid <= 1'b0;
        end
        if (w && s_axi_wready === 1'b1) begin
          w = 1'b0;
          s_axi_wvalid <= 1'b0;
        end
      end
      while (s_axi_bvalid !== 1'b1 && n < 50) begin
        @(posedge mclk);
        n = n + 1;
      end
      chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
      s_axi_bready <= 1'b0;
    end
  endtask
  // Bus read and compare
  task rdc(input [11:0] idx, input [31:0] exp, input [1:0] er);
    integer n;
    begin
      @(posedge mclk);
      s_axi_araddr  <= {idx[9:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      while (s_axi_arready !== 1'b1 && n < 50) begin
        @(posedge mclk);
        n = n + 1;
      end
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1 && n < 50) begin
        @(posedge mclk);
        n = n + 1;
      end
      chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
      chk(s_axi_rdata, exp);
      s_axi_rready <= 1'b0;
    end
  endtask
  // Verdict and end of run
  task end_of_test;
    begin
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // ****************************************
  // Clock, watchdog, tests
  // ****************************************
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    n_errors = n_errors + 1;
    end_of_test;
  end
  // Main sequence
  initial begin
    n_errors = 0;
    checks = 0;
    {sys_rst, wdt_overflow, pin_low, brown} = 4'h8;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 24'h00_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    wait_cpu(1'b0);
    chk({21'h0, boot_addr_ff}, 32'h0000_0000);
    rdc(`RSQ_IDX_FLAGS, 32'h0000_0080, 2'h0);
    rdc(`RSQ_IDX_CTRL, 32'h0000_0001, 2'h0);
    rdc(`RSQ_IDX_SEQ_STAT, 32'h0000_00E4, 2'h0);
    rdc(12'h0090, 32'h0000_0000, 2'h2);
    wr(12'h0090, 32'h0000_00FF, 2'h2);
    wr(`RSQ_IDX_IRQ_STAT, 32'h0000_000F, 2'h0);
    rdc(`RSQ_IDX_IRQ_STAT, 32'h0000_0000, 2'h0);
    wr(`RSQ_IDX_IRQ_MASK, 32'h0000_0001, 2'h0);
    // Watchdog overflow
    @(posedge mclk);
    wdt_overflow <= 1'b1;
    @(posedge mclk);
    wdt_overflow <= 1'b0;
    wait_cpu(1'b1);
    wait_cpu(1'b0);
    rdc(`RSQ_IDX_FLAGS, 32'h0000_0000, 2'h0);
    rdc(`RSQ_IDX_IRQ_STAT, 32'h0000_0009, 2'h0);
    chk({31'h0, irq_ff}, 32'h0000_0001);
    wr(`RSQ_IDX_IRQ_MASK, 32'h0000_0000, 2'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq_ff}, 32'h0000_0000);
    // Write with lane zero off has no effect but answers OKAY
    s_axi_wstrb <= 4'h0;
    wr(`RSQ_IDX_IRQ_MASK, 32'h0000_0001, 2'h0);
    rdc(`RSQ_IDX_IRQ_MASK, 32'h0000_0000, 2'h0);
    s_axi_wstrb <= 4'hF;
    // External pin held low, then released
    pin_low <= 1'b1;
    wait_cpu(1'b1);
    repeat (30) @(posedge mclk);
    chk({31'h0, cpu_rst_ff}, 32'h0000_0001);
    pin_low <= 1'b0;
    wait_cpu(1'b0);
    rdc(`RSQ_IDX_FLAGS, 32'h0000_00C0, 2'h0);
    // Pin ignored with the option off
    wr(`RSQ_IDX_CTRL, 32'h0000_0000, 2'h0);
    pin_low <= 1'b1;
    repeat (30) @(posedge mclk);
    chk({31'h0, cpu_rst_ff}, 32'h0000_0000);
    pin_low <= 1'b0;
    repeat (8) @(posedge mclk);
    wr(`RSQ_IDX_CTRL, 32'h0000_0001, 2'h0);
    // Software may rewrite the cause and the core flags
    wr(`RSQ_IDX_FLAGS, 32'h0000_0007, 2'h0);
    rdc(`RSQ_IDX_FLAGS, 32'h0000_0007, 2'h0);
    // Brown-out held, then supply back
    brown <= 1'b1;
    wait_cpu(1'b1);
    repeat (30) @(posedge mclk);
    chk({31'h0, cpu_rst_ff}, 32'h0000_0001);
    brown <= 1'b0;
    wait_cpu(1'b0);
    rdc(`RSQ_IDX_FLAGS, 32'h0000_0080, 2'h0);
    end_of_test;
  end
endmodule // rsq_reset_sequencer_bench

// ===== bench/rsq_seq_asserts.sv
// Port assertions for the reset sequencer
`timescale 1ns/100ps
module rsq_seq_asserts (
  // Clock and reset
  input wire        mclk,
  input wire        sys_rst,
  // Supply, oscillator, watchdog
  input wire        supply_ok,
  input wire        supply_drop_detector,
  input wire        osc_ready,
  input wire        wdt_overflow,
  // Core control
  input wire        cpu_rst_ff,
  input wire        pc_clear_ff,
  input wire        reg_init_ff,
  input wire        mode_normal_ff,
  input wire        fetch_start_ff,
  input wire [10:0] boot_addr_ff,
  // Bus answers
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Sequences
  // ****************************************
  // Init cycle just ended
  sequence init_done;
    reg_init_ff ##1 !reg_init_ff;
  endsequence
  // Core leaves reset
  sequence release_edge;
    $fell(cpu_rst_ff);
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  // pc clear tracks
  pc_clear_a: assert property (pc_clear_ff == cpu_rst_ff)
    else $error("pc clear differs from core reset");
  fetch_pulse_a: assert property (release_edge |->
    fetch_start_ff ##1 !fetch_start_ff)
    else $error("fetch pulse missing at release");
  boot_zero_a: assert property (boot_addr_ff == 11'h000)
    else $error("boot address not zero");
  mode_normal_a: assert property (cpu_rst_ff |-> mode_normal_ff)
    else $error("normal mode not forced in reset");
  wdt_reset_a: assert property (!cpu_rst_ff && wdt_overflow
    |-> ##[1:4] cpu_rst_ff)
    else $error("overflow did not reset core");
  drop_reset_a: assert property (supply_drop_detector[*8]
    |-> cpu_rst_ff)
    else $error("supply drop did not reset core");
  warm_hold_a: assert property (init_done |-> cpu_rst_ff[*6])
    else $error("release too soon after init");
  osc_first_a: assert property (release_edge |->
    $past(osc_ready, 6))
    else $error("release without oscillator");
  supply_first_a: assert property (release_edge |->
    $past(supply_ok, 6))
    else $error("release with supply low");
  // Write answer leaves only through a handshake, else held
  bresp_hold_a: assert property (s_axi_bvalid |=> $past(s_axi_bready)
    || (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write answer dropped early");
  // Read answer leaves only through a handshake, else held
  rdata_hold_a: assert property (s_axi_rvalid |=> $past(s_axi_rready)
    || (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read answer dropped early");
endmodule // rsq_seq_asserts

bind rsq_reset_sequencer rsq_seq_asserts u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .supply_ok(supply_ok),
  .supply_drop_detector(supply_drop_detector),
  .osc_ready(osc_ready), .wdt_overflow(wdt_overflow),
  .cpu_rst_ff(cpu_rst_ff), .pc_clear_ff(pc_clear_ff),
  .reg_init_ff(reg_init_ff), .mode_normal_ff(mode_normal_ff),
  .fetch_start_ff(fetch_start_ff), .boot_addr_ff(boot_addr_ff),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ===== shared/rsq_defs.vh
// Constants for the system reset sequencer
`ifndef RSQ_DEFS_VH
`define RSQ_DEFS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define RSQ_IDX_FLAGS     12'h0086
`define RSQ_IDX_CTRL      12'h0087
`define RSQ_IDX_IRQ_STAT  12'h0088
`define RSQ_IDX_IRQ_MASK  12'h0089
`define RSQ_IDX_SEQ_STAT  12'h008A

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define RSQ_CAUSE_HI_BIT  7
`define RSQ_CAUSE_LO_BIT  6
`define RSQ_CAUSE_WDT     2'h0
`define RSQ_CAUSE_RSVD    2'h1
`define RSQ_CAUSE_POR     2'h2
`define RSQ_CAUSE_EXT     2'h3
`define RSQ_EV_WDT        0
`define RSQ_EV_DROP       1
`define RSQ_EV_EXT        2
`define RSQ_EV_RUN        3

// ****************************************************************
// Reset values
// ****************************************************************
`define RSQ_FLAGS_RST     8'h80
`define RSQ_CTRL_RST      8'h01
`define RSQ_MASK_RST      4'h0
`define RSQ_BOOT_ADDR     11'h000

// ****************************************************************
// Timing
// ****************************************************************
`define RSQ_CLK_MHZ       100
`define RSQ_SUPPLY_NS     1000
`define RSQ_WARM_NS       2000
`define RSQ_SUPPLY_CYC    ((`RSQ_SUPPLY_NS*`RSQ_CLK_MHZ+999)/1000)
`define RSQ_WARM_CYC      ((`RSQ_WARM_NS*`RSQ_CLK_MHZ+999)/1000)

`endif

// ===== verilog/rsq_reset_sequencer.v
// Reset sequencer with cause flags and AXI4-Lite registers
`timescale 1ns/100ps
`include "rsq_defs.vh"

// How it works
// - Power-on, watchdog, brown-out, gated external reset
// - Any reset halts core, clears registers, PC
// - Release starts fetching at address zero
// - Cause code kept in flag bits 7:6
// - Cause flags stay readable after boot
// - Power-on waits for stable supply first
// - Enabled pin held low keeps device reset
// - Wait oscillator warm-up before execution
// - Watchdog reset skips the supply wait
// - Watchdog reset returns core to normal mode
// - Watchdog overflow input requests reset
// - Low supply resets, records power-on code
// - Low supply blocks completion of sequence
// - External pin active low, option gated
module rsq_reset_sequencer #(
  parameter SUPPLY_CYC = `RSQ_SUPPLY_CYC,
  parameter WARM_CYC   = `RSQ_WARM_CYC
) (
  // Clock and power-on reset
  input  wire        mclk,
  input  wire        sys_rst,
  // Pins and detectors (asynchronous)
  input  wire        ext_rst_n_pin,
  input  wire        supply_ok,
  input  wire        supply_drop_detector,
  input  wire        osc_ready,
  // Watchdog overflow (same clock)
  input  wire        wdt_overflow,
  // Core control
  output reg         cpu_rst_ff,
  output reg         pc_clear_ff,
  output reg         reg_init_ff,
  output reg         mode_normal_ff,
  output reg         fetch_start_ff,
  output reg  [10:0] boot_addr_ff,
  output reg         irq_ff,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ****************************************************************
  // States and local constants
  // ****************************************************************
  localparam [2:0] ST_SUPPLY = 3'b000;  // Waiting for stable supply
  localparam [2:0] ST_PIN    = 3'b001;  // Waiting for pin release
  localparam [2:0] ST_INIT   = 3'b010;  // Register initialisation
  localparam [2:0] ST_WARM   = 3'b011;  // Oscillator warm-up
  localparam [2:0] ST_RUN    = 3'b100;  // Program executing
  localparam [1:0] RESP_OK   = 2'b00;
  localparam [1:0] RESP_ERR  = 2'b10;
  localparam [31:0] SUP_END   = SUPPLY_CYC - 1;  // Full-width last count
  localparam [31:0] WARM_END  = WARM_CYC - 1;
  // Counter is 16 bits; longer waits need a wider counter
  localparam [15:0] SUP_LAST  = SUP_END[15:0];
  localparam [15:0] WARM_LAST = WARM_END[15:0];
  localparam [7:0]  FLAGS_RST = `RSQ_FLAGS_RST;  // Flag register at reset
  localparam [7:0]  CTRL_RST  = `RSQ_CTRL_RST;   // Control at reset

  // Byte address of a register index
  function [11:0] idx_addr;
    input [11:0] idx;
    begin
      idx_addr = {idx[9:0], 2'b00};
    end
  endfunction

  // ****************************************************************
  // Signals
  // ****************************************************************
  wire [3:0]  sync_q;          // Filtered asynchronous inputs
  wire        pin_high;        // External pin released
  wire        supply_good;     // Supply in operating range
  wire        supply_low;      // Drop detector firing
  wire        osc_good;        // Oscillator delivering clock
  reg  [2:0]  state_ff;        // Sequencer state
  reg  [2:0]  nxt_state;
  reg  [15:0] cnt_ff;          // Stability and warm-up counter
  reg  [15:0] nxt_cnt;
  reg  [1:0]  cause_ff;        // Reset cause flags
  reg  [1:0]  nxt_cause;
  reg         cause_set;       // Hardware updates cause this cycle
  reg  [3:0]  ev;              // One-cycle event strobes
  reg  [2:0]  alu_flags_ff;    // Carry, half carry, zero
  reg         ext_en_ff;       // External pin option
  reg  [3:0]  irq_stat_ff;     // Sticky events
  reg  [3:0]  irq_mask_ff;     // Interrupt enables
  reg         aw_held_ff;      // Write address captured
  reg         w_held_ff;       // Write data captured
  reg  [11:0] waddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  wire        do_write;
  wire        wr_lane0;
  reg  [3:0]  w1c;             // Interrupt clear mask this cycle

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // synchronise requests
  rsq_sync3 #(
    .W       (4),
    .RST_VAL (4'b0001)
  ) u_sync (
    .clk      (mclk),
    .rst      (sys_rst),
    .async_in ({osc_ready, supply_drop_detector, supply_ok,
                ext_rst_n_pin}),
    .sync_out (sync_q)
  );

  assign pin_high    = sync_q[0];
  assign supply_good = sync_q[1];
  assign supply_low  = sync_q[2];
  assign osc_good    = sync_q[3];

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = 16'h0000;
    nxt_cause = cause_ff;
    cause_set = 1'b0;
    ev        = 4'h0;
    if (supply_low) begin
      nxt_state = ST_SUPPLY;
      nxt_cause = `RSQ_CAUSE_POR;
      cause_set = 1'b1;
      ev[`RSQ_EV_DROP] = (state_ff != ST_SUPPLY);
    end else if (ext_en_ff && !pin_high &&
                 (state_ff != ST_SUPPLY) && (state_ff != ST_PIN)) begin
      nxt_state = ST_PIN;
      nxt_cause = `RSQ_CAUSE_EXT;
      cause_set = 1'b1;
      ev[`RSQ_EV_EXT] = 1'b1;
    end else if (wdt_overflow && (state_ff == ST_RUN)) begin
      nxt_state = ST_INIT;
      nxt_cause = `RSQ_CAUSE_WDT;
      cause_set = 1'b1;
      ev[`RSQ_EV_WDT] = 1'b1;
    end else begin
      case (state_ff)
        ST_SUPPLY: begin
          if (supply_good) begin
            if (cnt_ff == SUP_LAST)
              nxt_state = ST_PIN;
            else
              nxt_cnt = cnt_ff + 16'h0001;
          end
        end
        ST_PIN: begin
          if (!ext_en_ff || pin_high)
            nxt_state = ST_INIT;
        end
        ST_INIT: begin
          if (!supply_good)
            nxt_state = ST_SUPPLY;
          else
            nxt_state = ST_WARM;
        end
        ST_WARM: begin
          if (!supply_good) begin
            nxt_state = ST_SUPPLY;
          end else if (osc_good) begin
            if (cnt_ff == WARM_LAST) begin
              nxt_state = ST_RUN;
              ev[`RSQ_EV_RUN] = 1'b1;
            end else begin
              nxt_cnt = cnt_ff + 16'h0001;
            end
          end
        end
        ST_RUN: begin
          nxt_state = ST_RUN;
        end
        default: begin
          nxt_state = ST_SUPPLY;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sequencer registers and core control outputs
  // ****************************************************************
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff       <= ST_SUPPLY;
      cnt_ff         <= 16'h0000;
      cpu_rst_ff     <= 1'b1;
      pc_clear_ff    <= 1'b1;
      reg_init_ff    <= 1'b0;
      mode_normal_ff <= 1'b1;
      fetch_start_ff <= 1'b0;
      boot_addr_ff   <= `RSQ_BOOT_ADDR;
    end else begin
      state_ff       <= nxt_state;
      cnt_ff         <= nxt_cnt;
      cpu_rst_ff     <= (nxt_state != ST_RUN);
      pc_clear_ff    <= (nxt_state != ST_RUN);
      reg_init_ff    <= (nxt_state == ST_INIT);
      mode_normal_ff <= (nxt_state != ST_RUN);
      fetch_start_ff <= ev[`RSQ_EV_RUN];
      boot_addr_ff   <= `RSQ_BOOT_ADDR;
    end
  end

  // ****************************************************************
  // AXI4-Lite write channels; address and data in either order
  // ****************************************************************
  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_lane0 = do_write && wstrb_ff[0];

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      waddr_ff      <= 12'h000;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end else begin
      // Ready pulses for one cycle when a channel is taken
      s_axi_awready <= !aw_held_ff && s_axi_awvalid && !s_axi_awready;
      s_axi_wready  <= !w_held_ff && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        waddr_ff   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (waddr_ff)
          idx_addr(`RSQ_IDX_FLAGS),    idx_addr(`RSQ_IDX_CTRL),
          idx_addr(`RSQ_IDX_IRQ_STAT), idx_addr(`RSQ_IDX_IRQ_MASK),
          idx_addr(`RSQ_IDX_SEQ_STAT): s_axi_bresp <= RESP_OK;
          default:                     s_axi_bresp <= RESP_ERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Status flags, control and interrupt registers
  // ****************************************************************
  always @* begin
    w1c = 4'h0;
    if (wr_lane0 && (waddr_ff == idx_addr(`RSQ_IDX_IRQ_STAT)))
      w1c = wdata_ff[3:0];
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_ff     <= FLAGS_RST[`RSQ_CAUSE_HI_BIT:`RSQ_CAUSE_LO_BIT];
      alu_flags_ff <= 3'b000;
      ext_en_ff    <= CTRL_RST[0];
      irq_stat_ff  <= 4'h0;
      irq_mask_ff  <= `RSQ_MASK_RST;
      irq_ff       <= 1'b0;
    end else begin
      if (cause_set)
        cause_ff <= nxt_cause;
      else if (wr_lane0 && (waddr_ff == idx_addr(`RSQ_IDX_FLAGS)))
        cause_ff <= wdata_ff[`RSQ_CAUSE_HI_BIT:`RSQ_CAUSE_LO_BIT];
      if (nxt_state != ST_RUN)
        alu_flags_ff <= 3'b000;
      else if (wr_lane0 && (waddr_ff == idx_addr(`RSQ_IDX_FLAGS)))
        alu_flags_ff <= wdata_ff[2:0];
      if (wr_lane0 && (waddr_ff == idx_addr(`RSQ_IDX_CTRL)))
        ext_en_ff <= wdata_ff[0];
      if (wr_lane0 && (waddr_ff == idx_addr(`RSQ_IDX_IRQ_MASK)))
        irq_mask_ff <= wdata_ff[3:0];
      // New event wins over a same-cycle clear
      irq_stat_ff <= (irq_stat_ff & ~w1c) | ev;
      irq_ff      <= |(((irq_stat_ff & ~w1c) | ev) & irq_mask_ff);
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else begin
      // One read in flight; accept only when no data pending
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OK;
        case (s_axi_araddr)
          idx_addr(`RSQ_IDX_FLAGS):
            s_axi_rdata <= {24'h00_0000, cause_ff, 3'b000, alu_flags_ff};
          idx_addr(`RSQ_IDX_CTRL):
            s_axi_rdata <= {31'h0000_0000, ext_en_ff};
          idx_addr(`RSQ_IDX_IRQ_STAT):
            s_axi_rdata <= {28'h000_0000, irq_stat_ff};
          idx_addr(`RSQ_IDX_IRQ_MASK):
            s_axi_rdata <= {28'h000_0000, irq_mask_ff};
          idx_addr(`RSQ_IDX_SEQ_STAT):
            s_axi_rdata <= {24'h00_0000, supply_good, osc_good, pin_high,
                            2'b00, state_ff};
          default: begin
            // Unmapped: zero data, slave error
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // rsq_reset_sequencer

// ===== verilog/rsq_sync3.v
// Three-flop synchroniser with agreement filter
`timescale 1ns/100ps
module rsq_sync3 #(
  parameter             W       = 1,
  parameter [W-1:0]     RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Asynchronous inputs and filtered outputs
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] s1_ff;  // Metastable stage, read only by s2
  reg [W-1:0] s2_ff;  // Second stage
  reg [W-1:0] s3_ff;  // Third stage

  // ****************************************************************
  // Shift chain; output follows only when stages two and three agree
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff    <= RST_VAL;
      s2_ff    <= RST_VAL;
      s3_ff    <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      s1_ff    <= async_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      // Per bit: a single-cycle glitch never passes
      sync_out <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & sync_out);
    end
  end

endmodule // rsq_sync3
